/* src/tsa_pkg.sv */
// Shared constants, opcodes and state types of the tag state and anticollision block
package tsa_pkg;
  // Clock and link timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int BIT_TIME_NS = 9440;
  localparam int BIT_CYC = (BIT_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int SUBC_HALF_NS = 590;
  localparam int SUBC_CYC = (SUBC_HALF_NS * CLK_FREQ_MHZ) / 1000;
  localparam logic [9:0] BIT_LAST = 10'(BIT_CYC - 1);
  localparam logic [6:0] SUBC_LAST = 7'(SUBC_CYC - 1);
  // Character and frame shape, in bit times
  localparam logic [3:0] CHAR_LAST = 4'h9;
  localparam logic [3:0] SOF_LOW_BITS = 4'ha;
  localparam logic [3:0] SOF_LAST = 4'hb;
  localparam logic [3:0] EOF_LAST = 4'h9;
  // Request buffer, bytes including the two check bytes; reply payload cap in bytes
  localparam int RX_DEPTH = 8;
  localparam logic [3:0] RX_MAX = 4'h8;
  localparam logic [3:0] CRC_BYTES = 4'h2;
  localparam logic [3:0] TX_MAX = 4'h8;
  // Frame check
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
  // Random source and identifier reset value
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;
  localparam logic [7:0] ID_RESET = 8'h00;
  // Command opcodes
  localparam logic [7:0] OP_BEGIN = 8'h06;
  localparam logic [7:0] OP_ZERO_CALL = 8'h04;
  localparam logic [7:0] OP_PROBE = 8'h05;
  localparam logic [7:0] OP_CHOOSE = 8'h0e;
  localparam logic [7:0] OP_RETIRE = 8'h0f;
  localparam logic [7:0] OP_FETCH = 8'h08;
  localparam logic [7:0] OP_STORE = 8'h09;
  localparam logic [7:0] OP_CLONE = 8'h0a;
  localparam logic [7:0] OP_UID = 8'h0b;

  typedef enum logic [4:0] {
    ST_READY = 5'h01,
    ST_INVENTORY = 5'h02,
    ST_SELECTED = 5'h04,
    ST_DESELECTED = 5'h08,
    ST_DEACTIVATED = 5'h10
  } tsa_state_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_SOF = 4'h2,
    TX_CHAR = 4'h4,
    TX_EOF = 4'h8
  } tsa_tx_t;
endpackage

/* src/tsa_char_if.sv */
// Character stream from the deserializer to the command logic
`timescale 1ns/1ps
`default_nettype none
interface tsa_char_if;
  logic frame_sof;
  logic frame_eof;
  logic char_valid;
  logic char_err;
  logic [7:0] char_data;
  modport src (output frame_sof, output frame_eof, output char_valid, output char_err, output char_data);
  modport dst (input frame_sof, input frame_eof, input char_valid, input char_err, input char_data);
endinterface
`default_nettype wire

/* src/tsa_char_rx.sv */
// Request deserializer: 10-bit characters, start bit first
`timescale 1ns/1ps
`default_nettype none
module tsa_char_rx (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rx_bit,
  input wire logic rx_bit_strobe,
  input wire logic rx_sof,
  input wire logic rx_eof,
  tsa_char_if.src chr
);
  logic [9:0] shift_r;
  logic [3:0] cnt_r;

  // Shift bits in LSB first, emit data with framing check
  // ten-bit character assembly
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_r <= 10'h000;
      cnt_r <= 4'h0;
      chr.frame_sof <= 1'b0;
      chr.frame_eof <= 1'b0;
      chr.char_valid <= 1'b0;
      chr.char_err <= 1'b0;
      chr.char_data <= 8'h00;
    end else begin
      chr.frame_sof <= rx_sof;
      chr.frame_eof <= rx_eof & ~rx_sof;
      chr.char_valid <= 1'b0;
      if (rx_sof || rx_eof) begin
        cnt_r <= 4'h0;
      end else if (rx_bit_strobe) begin
        shift_r <= {rx_bit, shift_r[9:1]};
        if (cnt_r == tsa_pkg::CHAR_LAST) begin
          cnt_r <= 4'h0;
          chr.char_valid <= 1'b1;
          chr.char_data <= shift_r[9:2];
          chr.char_err <= shift_r[1] | ~rx_bit;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

  char_on_strobe_a: assert property (@(posedge ref_clk) disable iff (reset)
    chr.char_valid |-> $past(rx_bit_strobe) && $past(cnt_r) == tsa_pkg::CHAR_LAST)
    else $error("character emitted without tenth bit");
endmodule
`default_nettype wire

/* src/tsa_crc16.sv */
// Byte-wide reflected CRC-16 accumulator
`timescale 1ns/1ps
`default_nettype none
module tsa_crc16 (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic byte_en,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc
);
  // One byte through the polynomial, LSB first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ tsa_pkg::CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // Accumulator, restarted by clear
  always_ff @(posedge ref_clk) begin
    if (reset || clear) begin
      crc <= tsa_pkg::CRC_INIT;
    end else if (byte_en) begin
      crc <= crc_step(crc, byte_in);
    end
  end
endmodule
`default_nettype wire

/* src/tsa_tag_state.sv */
// Tag command state machine, anticollision responder and reply framer
`timescale 1ns/1ps
`default_nettype none
module tsa_tag_state (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rx_bit,
  input wire logic rx_bit_strobe,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic mem_rsp_valid,
  input wire logic [3:0] mem_rsp_len,
  input wire logic [63:0] mem_rsp_data,
  output logic tx_frame,
  output logic tx_bit,
  output logic tx_bpsk,
  output logic mem_req,
  output logic [7:0] mem_op,
  output logic [39:0] mem_arg,
  output logic [7:0] session_tag_identifier,
  output logic [4:0] tag_state
);
  tsa_pkg::tsa_state_t state_r;
  tsa_pkg::tsa_tx_t tx_state_r;
  logic [15:0] lfsr_r;
  logic [7:0] id_r;
  logic id_loaded_r;
  logic answered_r;
  logic [7:0] rx_buf_r [tsa_pkg::RX_DEPTH];
  logic [3:0] rx_cnt_r;
  logic rx_err_r;
  logic rx_in_frame_r;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [63:0] tx_pay_r;
  logic [3:0] tx_len_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] char_idx_r;
  logic [9:0] cur_char_r;
  logic [9:0] bit_div_r;
  logic [6:0] subc_div_r;
  logic subc_r;
  logic tx_frame_r;
  logic tx_bit_r;
  logic tx_bpsk_r;
  logic mem_req_r;
  logic mem_wait_r;
  logic [7:0] mem_op_r;
  logic [39:0] mem_arg_r;
  logic [7:0] op;
  logic [7:0] p1;
  logic [3:0] exp_len;
  logic frame_ok;
  logic do_begin;
  logic do_zero;
  logic zero_hit;
  logic do_probe;
  logic probe_hit;
  logic do_choose_hit;
  logic do_choose_miss;
  logic do_retire;
  logic do_mem;
  logic reply_now;
  logic [7:0] reply_byte;
  logic mem_done;
  logic tx_start;
  logic tx_idle;
  logic bit_tick;
  logic sof_done;
  logic char_done;
  logic last_char;
  logic [3:0] load_idx;
  logic tx_crc_en;
  logic bit_val;

  tsa_char_if chr_if ();

  tsa_char_rx u_char_rx (
    .ref_clk(ref_clk),
    .reset(reset),
    .rx_bit(rx_bit),
    .rx_bit_strobe(rx_bit_strobe),
    .rx_sof(rx_sof),
    .rx_eof(rx_eof),
    .chr(chr_if)
  );

  tsa_crc16 u_rx_crc (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(chr_if.frame_sof),
    .byte_en(chr_if.char_valid & rx_in_frame_r),
    .byte_in(chr_if.char_data),
    .crc(rx_crc)
  );

  tsa_crc16 u_tx_crc (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(tx_start),
    .byte_en(tx_crc_en),
    .byte_in(tx_pay_r[{load_idx[2:0], 3'h0} +: 8]),
    .crc(tx_crc)
  );

  // Request length without check bytes; zero marks an unknown opcode
  function automatic logic [3:0] cmd_len(input logic [7:0] code);
    unique case (code)
      tsa_pkg::OP_BEGIN, tsa_pkg::OP_ZERO_CALL, tsa_pkg::OP_RETIRE, tsa_pkg::OP_UID: cmd_len = 4'h1;
      tsa_pkg::OP_PROBE, tsa_pkg::OP_CHOOSE, tsa_pkg::OP_FETCH, tsa_pkg::OP_CLONE: cmd_len = 4'h2;
      tsa_pkg::OP_STORE: cmd_len = 4'h6;
      default: cmd_len = 4'h0;
    endcase
  endfunction

  // Next character to send: payload, then inverted check low and high
  function automatic logic [9:0] char_of(input logic [3:0] idx);
    logic [7:0] b;
    if (idx < tx_len_r) begin
      b = tx_pay_r[{idx[2:0], 3'h0} +: 8];
    end else if (idx == tx_len_r) begin
      b = ~tx_crc[7:0];
    end else begin
      b = ~tx_crc[15:8];
    end
    return {1'b1, b, 1'b0};
  endfunction

  // Free-running random source
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lfsr_r <= tsa_pkg::LFSR_SEED;
    end else begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ tsa_pkg::LFSR_TAPS) : (lfsr_r >> 1);
    end
  end

  // Request byte count and error tracking
  // frame delimited by start and end marks
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_cnt_r <= 4'h0;
      rx_err_r <= 1'b0;
      rx_in_frame_r <= 1'b0;
    end else if (chr_if.frame_sof) begin
      rx_cnt_r <= 4'h0;
      rx_err_r <= 1'b0;
      rx_in_frame_r <= 1'b1;
    end else if (chr_if.frame_eof) begin
      rx_in_frame_r <= 1'b0;
    end else if (chr_if.char_valid && rx_in_frame_r) begin
      if (rx_cnt_r == tsa_pkg::RX_MAX) begin
        rx_err_r <= 1'b1;
      end else begin
        rx_cnt_r <= rx_cnt_r + 4'h1;
      end
      if (chr_if.char_err) begin
        rx_err_r <= 1'b1;
      end
    end
  end

  // Request byte storage
  always_ff @(posedge ref_clk) begin
    if (chr_if.char_valid && rx_in_frame_r && rx_cnt_r != tsa_pkg::RX_MAX) begin
      rx_buf_r[rx_cnt_r[2:0]] <= chr_if.char_data;
    end
  end

  // Frame acceptance and per-state command decode
  // bad opcode, length or check is dropped silently
  assign op = rx_buf_r[0];
  assign p1 = rx_buf_r[1];
  assign exp_len = cmd_len(op);
  assign tx_idle = (tx_state_r == tsa_pkg::TX_IDLE);
  assign frame_ok = chr_if.frame_eof & rx_in_frame_r & ~rx_err_r & (exp_len != 4'h0)
                  & (rx_cnt_r == exp_len + tsa_pkg::CRC_BYTES) & (rx_crc == tsa_pkg::CRC_RESIDUE)
                  & tx_idle & ~mem_wait_r;
  // begin only from ready or inventory
  assign do_begin = frame_ok & (op == tsa_pkg::OP_BEGIN)
                  & (state_r == tsa_pkg::ST_READY || state_r == tsa_pkg::ST_INVENTORY);
  // fresh nibble, answer only on zero
  assign do_zero = frame_ok & (op == tsa_pkg::OP_ZERO_CALL) & (state_r == tsa_pkg::ST_INVENTORY);
  assign zero_hit = do_zero & (lfsr_r[3:0] == 4'h0);
  // slot index against nibble, once only
  assign do_probe = frame_ok & (op == tsa_pkg::OP_PROBE) & (state_r == tsa_pkg::ST_INVENTORY);
  assign probe_hit = do_probe & (p1[3:0] == id_r[3:0]) & ~answered_r;
  // matching choose-tag from inventory, selected or deselected
  assign do_choose_hit = frame_ok & (op == tsa_pkg::OP_CHOOSE) & (p1 == id_r)
                       & (state_r == tsa_pkg::ST_INVENTORY || state_r == tsa_pkg::ST_SELECTED
                          || state_r == tsa_pkg::ST_DESELECTED);
  assign do_choose_miss = frame_ok & (op == tsa_pkg::OP_CHOOSE) & (p1 != id_r) & (state_r == tsa_pkg::ST_SELECTED);
  assign do_retire = frame_ok & (op == tsa_pkg::OP_RETIRE) & (state_r == tsa_pkg::ST_SELECTED);
  // memory class served only when selected
  assign do_mem = frame_ok & (state_r == tsa_pkg::ST_SELECTED)
                & (op == tsa_pkg::OP_FETCH || op == tsa_pkg::OP_STORE || op == tsa_pkg::OP_CLONE || op == tsa_pkg::OP_UID);

  // Lifecycle state
  // reset lands in ready
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= tsa_pkg::ST_READY;
    end else begin
      unique case (state_r)
        tsa_pkg::ST_READY: begin
          if (do_begin) begin
            state_r <= tsa_pkg::ST_INVENTORY;
          end
        end
        tsa_pkg::ST_INVENTORY: begin
          if (do_choose_hit) begin
            state_r <= tsa_pkg::ST_SELECTED;
          end
        end
        tsa_pkg::ST_SELECTED: begin
          if (do_retire) begin
            state_r <= tsa_pkg::ST_DEACTIVATED;
          end else if (do_choose_miss) begin
            state_r <= tsa_pkg::ST_DESELECTED;
          end
        end
        tsa_pkg::ST_DESELECTED: begin
          if (do_choose_hit) begin
            state_r <= tsa_pkg::ST_SELECTED;
          end
        end
        // no way out but power loss
        tsa_pkg::ST_DEACTIVATED: begin
          state_r <= tsa_pkg::ST_DEACTIVATED;
        end
        default: begin
          state_r <= tsa_pkg::ST_READY;
        end
      endcase
    end
  end

  // Session identifier: LFSR_SEED low byte at power-up, redrawn by begin, slot nibble only redrawn by zero call
  // eight bits, slot nibble low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      id_r <= tsa_pkg::ID_RESET;
      id_loaded_r <= 1'b0;
    end else if (!id_loaded_r) begin
      id_r <= lfsr_r[7:0];
      id_loaded_r <= 1'b1;
    end else if (do_begin) begin
      id_r <= lfsr_r[7:0];
    end else if (do_zero) begin
      id_r[3:0] <= lfsr_r[3:0];
    end
  end

  // Once-per-sequence answer flag
  // slot answer at most once
  always_ff @(posedge ref_clk) begin
    if (reset || do_begin) begin
      answered_r <= 1'b0;
    end else if (do_zero) begin
      answered_r <= zero_hit;
    end else if (probe_hit) begin
      answered_r <= 1'b1;
    end
  end

  // Memory-side request and wait for its answer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_req_r <= 1'b0;
      mem_wait_r <= 1'b0;
      mem_op_r <= 8'h00;
      mem_arg_r <= 40'h00_0000_0000;
    end else begin
      mem_req_r <= do_mem;
      if (do_mem) begin
        mem_wait_r <= 1'b1;
        mem_op_r <= op;
        mem_arg_r <= {rx_buf_r[5], rx_buf_r[4], rx_buf_r[3], rx_buf_r[2], p1};
      end else if (mem_rsp_valid) begin
        mem_wait_r <= 1'b0;
      end
    end
  end

  // Reply source: own identifier or memory answer
  assign reply_now = do_begin | zero_hit | probe_hit | do_choose_hit;
  assign reply_byte = do_begin ? lfsr_r[7:0] : (zero_hit ? {id_r[7:4], lfsr_r[3:0]} : id_r);
  assign mem_done = mem_wait_r & mem_rsp_valid;
  assign tx_start = reply_now | (mem_done & (mem_rsp_len != 4'h0));

  // Reply payload latch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_pay_r <= 64'h0;
      tx_len_r <= 4'h0;
    end else if (tx_start) begin
      tx_pay_r <= reply_now ? {56'h0, reply_byte} : mem_rsp_data;
      tx_len_r <= reply_now ? 4'h1 : ((mem_rsp_len > tsa_pkg::TX_MAX) ? tsa_pkg::TX_MAX : mem_rsp_len);
    end
  end

  // Bit-rate divider, running only while a reply is on air
  always_ff @(posedge ref_clk) begin
    if (reset || tx_idle || bit_tick) begin
      bit_div_r <= 10'h000;
    end else begin
      bit_div_r <= bit_div_r + 10'h001;
    end
  end
  assign bit_tick = (bit_div_r == tsa_pkg::BIT_LAST);

  // Character sequencing and check accumulation
  assign sof_done = (tx_state_r == tsa_pkg::TX_SOF) & bit_tick & (bit_cnt_r == tsa_pkg::SOF_LAST);
  assign char_done = (tx_state_r == tsa_pkg::TX_CHAR) & bit_tick & (bit_cnt_r == tsa_pkg::CHAR_LAST);
  assign last_char = (char_idx_r == tx_len_r + 4'h1);
  assign load_idx = sof_done ? 4'h0 : char_idx_r + 4'h1;
  assign tx_crc_en = (sof_done | (char_done & ~last_char)) & (load_idx < tx_len_r);

  // Reply framer
  // SOF, payload, two check bytes, EOF
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_state_r <= tsa_pkg::TX_IDLE;
      bit_cnt_r <= 4'h0;
      char_idx_r <= 4'h0;
      cur_char_r <= 10'h000;
    end else begin
      unique case (tx_state_r)
        tsa_pkg::TX_IDLE: begin
          bit_cnt_r <= 4'h0;
          if (tx_start) begin
            tx_state_r <= tsa_pkg::TX_SOF;
          end
        end
        tsa_pkg::TX_SOF: begin
          if (sof_done) begin
            tx_state_r <= tsa_pkg::TX_CHAR;
            bit_cnt_r <= 4'h0;
            char_idx_r <= 4'h0;
            cur_char_r <= char_of(4'h0);
          end else if (bit_tick) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        tsa_pkg::TX_CHAR: begin
          if (char_done) begin
            bit_cnt_r <= 4'h0;
            if (last_char) begin
              tx_state_r <= tsa_pkg::TX_EOF;
            end else begin
              char_idx_r <= load_idx;
              cur_char_r <= char_of(load_idx);
            end
          end else if (bit_tick) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        tsa_pkg::TX_EOF: begin
          if (bit_tick && bit_cnt_r == tsa_pkg::EOF_LAST) begin
            tx_state_r <= tsa_pkg::TX_IDLE;
          end else if (bit_tick) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        default: begin
          tx_state_r <= tsa_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Baseband bit of the current frame element
  // start bit leaves first
  always_comb begin
    bit_val = 1'b0;
    if (tx_state_r == tsa_pkg::TX_SOF) begin
      bit_val = (bit_cnt_r >= tsa_pkg::SOF_LOW_BITS);
    end else if (tx_state_r == tsa_pkg::TX_CHAR) begin
      bit_val = cur_char_r[bit_cnt_r];
    end
  end

  // Subcarrier square wave and phase-keyed output
  // phase flips for a zero bit
  always_ff @(posedge ref_clk) begin
    if (reset || tx_idle) begin
      subc_div_r <= 7'h00;
      subc_r <= 1'b0;
    end else if (subc_div_r == tsa_pkg::SUBC_LAST) begin
      subc_div_r <= 7'h00;
      subc_r <= ~subc_r;
    end else begin
      subc_div_r <= subc_div_r + 7'h01;
    end
  end

  // Output flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_frame_r <= 1'b0;
      tx_bit_r <= 1'b0;
      tx_bpsk_r <= 1'b0;
    end else begin
      tx_frame_r <= ~tx_idle;
      tx_bit_r <= bit_val & ~tx_idle;
      tx_bpsk_r <= ~tx_idle & (subc_r ~^ bit_val);
    end
  end

  assign tx_frame = tx_frame_r;
  assign tx_bit = tx_bit_r;
  assign tx_bpsk = tx_bpsk_r;
  assign mem_req = mem_req_r;
  assign mem_op = mem_op_r;
  assign mem_arg = mem_arg_r;
  assign session_tag_identifier = id_r;
  assign tag_state = state_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence begin_seen_s;
    (state_r == tsa_pkg::ST_READY) ##0 do_begin;
  endsequence
  sequence sof_low_s;
    (tx_frame_r && !tx_bit_r) [*8];
  endsequence

  state_onehot_a: assert property ($onehot(state_r))
    else $error("state not one-hot");
  ready_begin_a: assert property (begin_seen_s |=> state_r == tsa_pkg::ST_INVENTORY && tx_state_r == tsa_pkg::TX_SOF)
    else $error("begin from ready did not enter inventory and answer");
  ready_ignore_a: assert property (state_r == tsa_pkg::ST_READY && !do_begin |=> state_r == tsa_pkg::ST_READY)
    else $error("ready left without begin");
  inventory_stay_a: assert property ((do_zero || do_probe || (do_begin && state_r == tsa_pkg::ST_INVENTORY))
    |=> state_r == tsa_pkg::ST_INVENTORY)
    else $error("anticollision command left inventory");
  begin_reply_a: assert property (do_begin |=> tx_pay_r[7:0] == id_r && tx_len_r == 4'h1)
    else $error("begin reply not the new identifier");
  zero_silent_a: assert property (do_zero && lfsr_r[3:0] != 4'h0 |=> tx_idle)
    else $error("zero call answered with nonzero nibble");
  probe_once_a: assert property (do_probe && answered_r |=> tx_idle)
    else $error("second answer in one sequence");
  choose_hit_a: assert property (do_choose_hit |=> state_r == tsa_pkg::ST_SELECTED)
    else $error("matching choose did not select");
  choose_miss_a: assert property (do_choose_miss |=> state_r == tsa_pkg::ST_DESELECTED)
    else $error("mismatched choose did not deselect");
  deact_hold_a: assert property (state_r == tsa_pkg::ST_DEACTIVATED |=> state_r == tsa_pkg::ST_DEACTIVATED)
    else $error("deactivated state left");
  bad_silent_a: assert property (chr_if.frame_eof && rx_crc != tsa_pkg::CRC_RESIDUE && tx_idle && !mem_wait_r
    |=> tx_idle)
    else $error("answer to a bad frame");
  sof_first_a: assert property ($rose(tx_frame_r) |-> sof_low_s)
    else $error("reply did not open with start of frame");
  bpsk_quiet_a: assert property (!tx_frame_r |-> !tx_bpsk_r)
    else $error("modulation outside a reply frame");
endmodule
`default_nettype wire

/* tb/tsa_reader_model.sv */
// Reader model that frames requests for the tag
`timescale 1ns/1ps
`default_nettype none
module tsa_reader_model (
  input wire logic ref_clk,
  output logic rx_bit,
  output logic rx_bit_strobe,
  output logic rx_sof,
  output logic rx_eof
);
  // Idle link
  initial begin
    rx_bit = 1'h1;
    rx_bit_strobe = 1'h0;
    rx_sof = 1'h0;
    rx_eof = 1'h0;
  end
  // Check bytes, complemented, low byte first
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction
  task automatic put_char(input logic [7:0] b);
    logic [9:0] ch;
    ch = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      rx_bit = ch[i];
      rx_bit_strobe = 1'h1;
      @(negedge ref_clk);
      rx_bit = ~ch[i];
      rx_bit_strobe = 1'h0;
    end
  endtask
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc_of(q) ^ {15'h0, bad};
    @(negedge ref_clk);
    rx_sof = 1'h1;
    @(negedge ref_clk);
    rx_sof = 1'h0;
    foreach (q[i]) put_char(q[i]);
    put_char(c[7:0]);
    put_char(c[15:8]);
    repeat (2) @(negedge ref_clk);
    rx_eof = 1'h1;
    @(negedge ref_clk);
    rx_eof = 1'h0;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the tag state block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic rx_bit, rx_bit_strobe, rx_sof, rx_eof, tx_frame, tx_bit, tx_bpsk, mem_req;
  logic mem_rsp_valid = 1'h0;
  logic [3:0] mem_rsp_len = 4'h0;
  logic [63:0] mem_rsp_data = 64'h0;
  logic [7:0] mem_op, sid, a, session_tag_identifier;
  logic [39:0] mem_arg;
  logic [4:0] tag_state, es;
  logic [51:0] bits, psk;
  logic [31:0] rng = 32'h3dad;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int nreq = 0;
  always #5 ref_clk = ~ref_clk;
  tsa_reader_model u_tsa_reader_model (.ref_clk(ref_clk), .rx_bit(rx_bit), .rx_bit_strobe(rx_bit_strobe),
    .rx_sof(rx_sof), .rx_eof(rx_eof));
  tsa_tag_state u_tsa_tag_state (.ref_clk(ref_clk), .reset(reset), .rx_bit(rx_bit), .rx_bit_strobe(rx_bit_strobe),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_len(mem_rsp_len),
    .mem_rsp_data(mem_rsp_data), .tx_frame(tx_frame), .tx_bit(tx_bit), .tx_bpsk(tx_bpsk), .mem_req(mem_req),
    .mem_op(mem_op), .mem_arg(mem_arg), .session_tag_identifier(session_tag_identifier), .tag_state(tag_state));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cycle ceiling and memory request count
  always @(negedge ref_clk) begin
    cyc++;
    nreq += mem_req;
    if (cyc == 110000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // State model of the tag lifecycle
  function automatic logic [4:0] nxt(input logic [4:0] s, input logic [7:0] op, input logic hit);
    if (s == tsa_pkg::ST_READY && op == tsa_pkg::OP_BEGIN) return tsa_pkg::ST_INVENTORY;
    if (s != tsa_pkg::ST_READY && s != tsa_pkg::ST_DEACTIVATED && op == tsa_pkg::OP_CHOOSE && hit)
      return tsa_pkg::ST_SELECTED;
    if (s == tsa_pkg::ST_SELECTED && op == tsa_pkg::OP_CHOOSE) return tsa_pkg::ST_DESELECTED;
    if (s == tsa_pkg::ST_SELECTED && op == tsa_pkg::OP_RETIRE) return tsa_pkg::ST_DEACTIVATED;
    return s;
  endfunction
  task automatic req(input logic [7:0] op, input logic [7:0] arg, input int n, input logic bad, input logic rep);
    logic [7:0] q[$];
    q = {op};
    if (n > 1) q.push_back(arg);
    u_tsa_reader_model.send(q, bad);
    repeat (6) @(negedge ref_clk);
    if (!bad) es = nxt(es, op, arg == sid);
    chk(tag_state, es);
    chk(tx_frame, rep);
  endtask
  // Sample each reply bit mid-cell
  task automatic reply;
    logic [15:0] c;
    logic [51:0] e;
    c = u_tsa_reader_model.crc_of({sid});
    e = {10'h0, 1'h1, c[15:8], 2'h1, c[7:0], 2'h1, sid, 1'h0, 2'h3, 10'h0};
    repeat (470) @(negedge ref_clk);
    for (int i = 0; i < 52; i++) begin
      bits[i] = tx_bit;
      // Sixteen subcarrier halves per bit, low at frame start: mid-cell phase follows the bit
      psk[i] = ~tx_bpsk;
      repeat (944) @(negedge ref_clk);
    end
    chk(bits, e);
    chk(psk, e);
    chk(tx_frame, 1'h0);
    chk(tx_bpsk, 1'h0);
  endtask
  initial begin
    es = tsa_pkg::ST_READY;
    repeat (16) @(negedge ref_clk);
    reset = 1'h0;
    repeat (2) @(negedge ref_clk);
    sid = session_tag_identifier;
    chk(tag_state, es);
    chk(sid, tsa_pkg::LFSR_SEED[7:0]);
    req(tsa_pkg::OP_ZERO_CALL, 8'h0, 1, 1'h0, 1'h0);
    req(tsa_pkg::OP_BEGIN, 8'h0, 1, 1'h1, 1'h0);
    req(tsa_pkg::OP_BEGIN, 8'h0, 1, 1'h0, 1'h1);
    sid = session_tag_identifier;
    reply();
    req(tsa_pkg::OP_CHOOSE, sid ^ 8'(xs() | 32'h1), 2, 1'h0, 1'h0);
    // probes carry a slot index from 1 to 15
    req(tsa_pkg::OP_PROBE, {4'h0, (sid[3:0] == 4'hf) ? 4'h1 : sid[3:0] + 4'h1}, 2, 1'h0, 1'h0);
    req(tsa_pkg::OP_FETCH, 8'h07, 2, 1'h0, 1'h0);
    req(tsa_pkg::OP_CHOOSE, sid, 2, 1'h0, 1'h1);
    reply();
    req(tsa_pkg::OP_ZERO_CALL, 8'h0, 1, 1'h0, 1'h0);
    a = 8'(xs());
    req(tsa_pkg::OP_FETCH, a, 2, 1'h0, 1'h0);
    chk({nreq[7:0], mem_op, mem_arg[7:0]}, {8'h1, tsa_pkg::OP_FETCH, a});
    mem_rsp_data = {xs(), xs()};
    mem_rsp_valid = 1'h1;
    @(negedge ref_clk);
    mem_rsp_valid = 1'h0;
    // one tag selected, deselected when another is chosen
    req(tsa_pkg::OP_CHOOSE, sid ^ 8'h80, 2, 1'h0, 1'h0);
    req(tsa_pkg::OP_BEGIN, 8'h0, 1, 1'h0, 1'h0);
    req(tsa_pkg::OP_CHOOSE, sid ^ 8'h01, 2, 1'h0, 1'h0);
    reset = 1'h1;
    @(negedge ref_clk);
    reset = 1'h0;
    es = tsa_pkg::ST_READY;
    repeat (2) @(negedge ref_clk);
    chk(tag_state, es);
    chk({tx_frame, tx_bit, tx_bpsk, mem_req}, 4'h0);
    chk(session_tag_identifier, tsa_pkg::LFSR_SEED[7:0]);
    wrap_up();
  end
endmodule
`default_nettype wire
